// ### core/rsbr_pkg.sv
// Purpose: Shared constants and types for the serial-bus recovery slave
// Assumes: 100 MHz system clock, link clock from the bus master
// Notes: No software-visible registers
package rsbr_pkg;
  localparam int SYS_CLK_HZ = 100000000;
  localparam int FFO_FREQ_HZ = 32768;
  // Half period of the fixed-frequency output, rounded down
  localparam int FFO_HALF_CYC = SYS_CLK_HZ / (2 * FFO_FREQ_HZ);
  localparam logic [10:0] FFO_HALF_CNT = 11'(FFO_HALF_CYC - 1);
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 9;

  typedef enum logic [2:0] {
    RSBR_IDLE,
    RSBR_ADDR,
    RSBR_ADDR_ACK,
    RSBR_WR_DATA,
    RSBR_WR_ACK,
    RSBR_RD_DATA,
    RSBR_RD_ACK
  } rsbr_state_t;

  // Received byte handed from the link domain to the system domain
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } rsbr_rx_word_t;
endpackage : rsbr_pkg

// ### core/rsbr_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock domain
// Notes: Flip-flop storage, depth a power of two
`timescale 1ns/1ps
`default_nettype none
module rsbr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic push;
  logic pop;
  logic full;
  logic empty;

  assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign empty = (wr_ptr_ff == rd_ptr_ff);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_ff <= '0;
    end else if (push) begin
      wr_ptr_ff <= wr_ptr_ff + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_ptr_ff <= '0;
    end else if (pop) begin
      rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end
endmodule : rsbr_fifo
`default_nettype wire

// ### core/rsbr_slave.sv
// Purpose: Two-wire slave front end with stuck-bus recovery behaviour
// Assumes: SCL is the link clock; SDA sampled on SCL edges
// Notes: Start and stop are seen by SDA-clocked detectors gated by SCL
// Summary of operation
// (RULE1) After an interrupted transfer the serial state is kept until reset by stop.
// (RULE2) No reset pin; a detected stop returns the interface to idle.
// (RULE3) While the slave drives SDA low, a stop is not recognised.
// (RULE4) While the slave drives SDA low, a start is not recognised.
// (RULE5) Master recovers with start, 63 clocks with SDA released, then stop.
// (RULE6) Slave releases SDA within the recovery clocks; next stop resets it.
// (RULE7) Master should run recovery at system initialisation.
// (RULE8) Recovery during a write acknowledge may commit that write.
// (RULE9) Master waits 0.5 s after power-on before any transfer.
// (RULE10) Master reads back first real-time group within 1 s of writing it.
// (RULE11) Master ends reads of correction or free register with not-acknowledge.
// (RULE12) A 32.768 kHz square wave is driven from power-on on the fixed output; code toggles every 1525 system clocks, about 32.787 kHz.
// (RULE13) Initialisation flow is optional if defaults are acceptable.
// (RULE14) Receiving, the slave pulls SDA low on the ninth clock as acknowledge.
// (RULE15) SDA change while SCL high is start or stop and aborts the transfer.
// (RULE16) Read data is shifted out most significant bit first, byte per ack.
// (RULE17) Clocks after release without a start change nothing.
`timescale 1ns/1ps
`default_nettype none
module rsbr_slave (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [6:0] dev_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_data_valid,
  output logic rd_req_ff,
  output logic wr_valid_ff,
  output logic [7:0] wr_data_ff,
  output logic wr_first_ff,
  input wire logic wr_ready,
  output logic stop_seen_ff,
  output logic fixed_freq_output
);
  localparam logic [3:0] BIT_LAST_L = rsbr_pkg::BIT_LAST;

  // Link domain: sda low drive, registered on SCL falling edge
  // Power-on values; no reset reaches the link side, only a stop does
  rsbr_pkg::rsbr_state_t state_ff = rsbr_pkg::RSBR_IDLE;
  logic [3:0] bit_ff = 4'h0;
  logic [7:0] shift_ff = 8'h00;
  logic drive_low_ff = 1'b0;
  logic rnw_ff = 1'b0;
  logic first_ff = 1'b0;
  logic push_tgl_ff = 1'b0;
  logic [7:0] push_data_ff = 8'h00;
  logic push_first_ff = 1'b0;
  logic rd_tgl_ff = 1'b0;
  logic start_tgl_ff = 1'b0;
  logic stop_tgl_ff = 1'b0;
  logic start_ack_ff = 1'b0;
  logic stop_ack_ff = 1'b0;
  logic [7:0] rd_latch_ff = 8'h00;

  // Start/stop detectors clocked by SDA edges, qualified by SCL high
  // Gating by the slave's own drive hides both conditions while it holds SDA low
  always_ff @(negedge sda_in) begin
    if (scl_clk && !drive_low_ff) begin // RULE4 RULE15
      start_tgl_ff <= !start_tgl_ff;
    end
  end

  always_ff @(posedge sda_in) begin
    if (scl_clk && !drive_low_ff) begin // RULE3 RULE15
      stop_tgl_ff <= !stop_tgl_ff;
    end
  end

  logic start_pend;
  logic stop_pend;
  assign start_pend = start_tgl_ff != start_ack_ff;
  assign stop_pend = stop_tgl_ff != stop_ack_ff;

  // Bit engine on SCL rising edge
  always_ff @(posedge scl_clk) begin
    start_ack_ff <= start_tgl_ff;
    stop_ack_ff <= stop_tgl_ff;
    if (stop_pend) begin
      state_ff <= rsbr_pkg::RSBR_IDLE; // RULE2 RULE6
      bit_ff <= '0;
    end else if (start_pend) begin
      state_ff <= rsbr_pkg::RSBR_ADDR; // RULE15
      bit_ff <= 4'h1;
      shift_ff <= {7'h00, sda_in};
      first_ff <= 1'b1;
    end else begin
      unique case (state_ff)
        rsbr_pkg::RSBR_IDLE: begin
          bit_ff <= '0; // RULE17
        end
        rsbr_pkg::RSBR_ADDR, rsbr_pkg::RSBR_WR_DATA: begin
          shift_ff <= {shift_ff[6:0], sda_in};
          bit_ff <= bit_ff + 4'h1;
          if (bit_ff == BIT_LAST_L) begin
            state_ff <= (state_ff == rsbr_pkg::RSBR_ADDR) ? rsbr_pkg::RSBR_ADDR_ACK : rsbr_pkg::RSBR_WR_ACK;
          end
        end
        rsbr_pkg::RSBR_ADDR_ACK: begin
          bit_ff <= '0;
          if (drive_low_ff) begin
            state_ff <= rnw_ff ? rsbr_pkg::RSBR_RD_DATA : rsbr_pkg::RSBR_WR_DATA;
          end else begin
            state_ff <= rsbr_pkg::RSBR_IDLE;
          end
        end
        rsbr_pkg::RSBR_WR_ACK: begin
          bit_ff <= '0;
          first_ff <= 1'b0;
          state_ff <= rsbr_pkg::RSBR_WR_DATA;
        end
        rsbr_pkg::RSBR_RD_DATA: begin
          bit_ff <= bit_ff + 4'h1;
          if (bit_ff == BIT_LAST_L) begin
            state_ff <= rsbr_pkg::RSBR_RD_ACK;
          end
        end
        rsbr_pkg::RSBR_RD_ACK: begin
          bit_ff <= '0;
          // Not-acknowledge ends the read and frees SDA
          state_ff <= sda_in ? rsbr_pkg::RSBR_IDLE : rsbr_pkg::RSBR_RD_DATA; // RULE11
        end
      endcase
    end
  end

  // Drive decision on SCL falling edge; state held across interruption
  always_ff @(negedge scl_clk) begin
    unique case (state_ff)
      rsbr_pkg::RSBR_ADDR_ACK: begin
        rnw_ff <= shift_ff[0];
        drive_low_ff <= (shift_ff[7:1] == dev_addr); // RULE1 RULE14
        rd_latch_ff <= rd_data;
      end
      rsbr_pkg::RSBR_WR_ACK: begin
        drive_low_ff <= 1'b1; // RULE14
        push_data_ff <= shift_ff;
        push_first_ff <= first_ff;
        push_tgl_ff <= !push_tgl_ff; // RULE8
      end
      rsbr_pkg::RSBR_RD_DATA: begin
        drive_low_ff <= !rd_latch_ff[BIT_LAST_L[2:0] - bit_ff[2:0]]; // RULE16
        if (bit_ff == BIT_LAST_L) begin
          rd_tgl_ff <= !rd_tgl_ff;
        end
      end
      default: begin
        drive_low_ff <= 1'b0; // RULE6 RULE17
        if (state_ff == rsbr_pkg::RSBR_RD_ACK) begin
          rd_latch_ff <= rd_data;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe <= drive_low_ff;
    end
  end

  // System-domain toggle synchronisers, three stages each
  logic [2:0] push_sync_ff;
  logic [2:0] rd_sync_ff;
  logic [2:0] stop_sync_ff;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      push_sync_ff <= '0;
      rd_sync_ff <= '0;
      stop_sync_ff <= '0;
    end else begin
      push_sync_ff <= {push_sync_ff[1:0], push_tgl_ff};
      rd_sync_ff <= {rd_sync_ff[1:0], rd_tgl_ff};
      stop_sync_ff <= {stop_sync_ff[1:0], stop_tgl_ff};
    end
  end

  // Data word is written on the same SCL edge as the toggle and settles during the synchroniser delay, then holds for a full byte
  rsbr_pkg::rsbr_rx_word_t rx_word;
  logic rx_valid;
  logic rx_ready;
  logic fifo_valid;
  rsbr_pkg::rsbr_rx_word_t fifo_word;
  assign rx_word = '{first: push_first_ff, data: push_data_ff};
  assign rx_valid = push_sync_ff[2] != push_sync_ff[1];

  rsbr_fifo #(
    .WIDTH(rsbr_pkg::FIFO_WIDTH),
    .DEPTH(rsbr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .rst(rst),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(rx_word),
    .out_valid(fifo_valid),
    .out_ready(wr_ready && !wr_valid_ff),
    .out_data(fifo_word)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_valid_ff <= 1'b0;
      wr_data_ff <= rsbr_pkg::BYTE_RESET;
      wr_first_ff <= 1'b0;
    end else if (fifo_valid && wr_ready && !wr_valid_ff) begin
      wr_valid_ff <= 1'b1;
      wr_data_ff <= fifo_word.data;
      wr_first_ff <= fifo_word.first;
    end else begin
      wr_valid_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_req_ff <= 1'b0;
      stop_seen_ff <= 1'b0;
    end else begin
      rd_req_ff <= (rd_sync_ff[2] != rd_sync_ff[1]) && !rd_data_valid;
      stop_seen_ff <= stop_sync_ff[2] != stop_sync_ff[1];
    end
  end

  // Free-running output, not held by reset so it runs from power-on
  logic [10:0] ffo_cnt_ff = 11'h000;
  logic ffo_ff = 1'b0;
  always_ff @(posedge sys_clk) begin
    if (ffo_cnt_ff >= rsbr_pkg::FFO_HALF_CNT) begin
      ffo_cnt_ff <= '0;
      ffo_ff <= !ffo_ff; // RULE12
    end else begin
      ffo_cnt_ff <= ffo_cnt_ff + 11'h001;
    end
  end

  assign fixed_freq_output = ffo_ff;
endmodule : rsbr_slave
`default_nettype wire

// ### sim/rsbr_master.sv
// Purpose: Bus master model making SCL and pulling SDA
// Assumes: SDA has a pull-up; drv_low pulls it low
// Notes: SCL idles high outside frames
`timescale 1ns/1ps
`default_nettype none
module rsbr_master (
  output var logic scl,
  output var logic drv_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    drv_low = 1'b0;
  end
  // Start is cond(0,1), stop is cond(1,0)
  // SCL falls 4 ns after and rises 1 ns before a system clock edge, so the two clocks never coincide
  task automatic cond(input logic x, input logic y);
    #4 scl = 1'b0;
    #7 drv_low = x;
    #8 scl = 1'b1;
    #7 drv_low = y;
    #4;
  endtask : cond
  // SDA only moves while SCL is low
  task automatic bitx(input logic b, output logic r);
    #4 scl = 1'b0;
    #7 drv_low = !b;
    #8 scl = 1'b1;
    #7 r = sda;
    #4;
  endtask : bitx
  task automatic xfer(input logic [7:0] d, input logic nack, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(nack, ack);
    ack = !ack;
  endtask : xfer
endmodule : rsbr_master
`default_nettype wire

// ### sim/rsbr_slave_chk.sv
// Purpose: Port checks for the recovery slave
// Assumes: Bound to rsbr_slave
// Notes: Square wave checked from its fourth edge
`timescale 1ns/1ps
`default_nettype none
module rsbr_slave_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic rd_req_ff,
  input wire logic wr_valid_ff,
  input wire logic stop_seen_ff,
  input wire logic fixed_freq_output
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic prev_ff = 1'b0;
  logic [1:0] seen_ff = 2'h0;
  logic [10:0] cnt_ff = 11'h000;
  wire chg = prev_ff != fixed_freq_output;
  // Start phase of the wave is arbitrary
  always_ff @(posedge sys_clk) begin
    prev_ff <= fixed_freq_output;
    cnt_ff <= chg ? 11'h000 : cnt_ff + 11'h001;
    seen_ff <= (chg && seen_ff != 2'h3) ? seen_ff + 2'h1 : seen_ff;
  end
  property p_ffo; chg && seen_ff == 2'h3 |-> cnt_ff == rsbr_pkg::FFO_HALF_CNT; endproperty
  a_ffo: assert property (p_ffo) else $error("wave period");
  property p_od; sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("sda driven high");
  property p_stq; stop_seen_ff |-> !sda_oe && !$past(sda_oe); endproperty
  a_stq: assert property (p_stq) else $error("stop while driving");
  property p_stp; stop_seen_ff |=> !stop_seen_ff; endproperty
  a_stp: assert property (p_stp) else $error("stop pulse");
  property p_rdp; rd_req_ff |=> !rd_req_ff; endproperty
  a_rdp: assert property (p_rdp) else $error("read pulse");
  property p_oeh; $rose(sda_oe) |=> sda_oe; endproperty
  a_oeh: assert property (p_oeh) else $error("ack too short");
  property p_rcl; $fell(rst) |-> !(wr_valid_ff || rd_req_ff || stop_seen_ff); endproperty
  a_rcl: assert property (p_rcl) else $error("reset value");
  property p_idl; stop_seen_ff |=> !sda_oe [*4]; endproperty
  a_idl: assert property (p_idl) else $error("busy after stop");
endmodule : rsbr_slave_chk
bind rsbr_slave rsbr_slave_chk rsbr_slave_chk_i (.sys_clk(sys_clk), .rst(rst), .sda_out(sda_out), .sda_oe(sda_oe),
  .rd_req_ff(rd_req_ff), .wr_valid_ff(wr_valid_ff), .stop_seen_ff(stop_seen_ff), .fixed_freq_output(fixed_freq_output));
`default_nettype wire

// ### sim/rtc_serial_bus_recovery_bench.sv
// Purpose: Self-checking bench for the recovery slave
// Assumes: Master model clocks SCL only in frames
// Notes: SDA is a wired AND with pull-up
`timescale 1ns/1ps
`default_nettype none
`define CHK(x, e) begin checks++; if ((x) !== (e)) begin fails++; $display("Error %0t: %h not %h", $time, x, e); end end
module rtc_serial_bus_recovery_bench;
  localparam logic [6:0] ADDR = 7'h32;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wr_ready = 1'b1;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] q;
  logic [7:0] wr_data_ff;
  logic a, scl, drv_low, sda_oe, rd_req_ff, wr_valid_ff, wr_first_ff, stop_seen_ff, ffo;
  logic [8:0] wq[$];
  int fails = 0, checks = 0, stops = 0, reqs = 0, cyc = 0, s;
  // Pull-up holds SDA high until the slave's enable leaves its power-on unknown
  wire sda = !(drv_low || (sda_oe === 1'b1));
  initial forever #5 sys_clk = !sys_clk;
  rsbr_master rsbr_master_i (.scl(scl), .drv_low(drv_low), .sda(sda));
  rsbr_slave rsbr_slave_i (.sys_clk(sys_clk), .rst(rst), .scl_clk(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .dev_addr(ADDR), .rd_data(rd_data), .rd_data_valid(1'b0), .rd_req_ff(rd_req_ff), .wr_valid_ff(wr_valid_ff),
    .wr_data_ff(wr_data_ff), .wr_first_ff(wr_first_ff), .wr_ready(wr_ready), .stop_seen_ff(stop_seen_ff),
    .fixed_freq_output(ffo));
  always @(posedge sys_clk) begin
    cyc++;
    if (wr_valid_ff === 1'b1 && wr_ready) wq.push_back({wr_first_ff, wr_data_ff});
    if (stop_seen_ff === 1'b1) stops++;
    if (rd_req_ff === 1'b1) reqs++;
    if (cyc == 30000) begin
      fails++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic x(input logic [7:0] d, input logic n);
    rsbr_master_i.xfer(d, n, q, a);
  endtask : x
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt
  task automatic t_write();
    wq.delete();
    s = stops;
    rsbr_master_i.cond(1'b0, 1'b1);
    x({ADDR, 1'b0}, 1'b1);
    `CHK(a, 1'b1)
    x(8'h3c, 1'b1);
    `CHK(a, 1'b1)
    rsbr_master_i.cond(1'b1, 1'b0);
    wt(10);
    `CHK(wq.size(), 1)
    `CHK(wq[0], 9'h13c)
    `CHK(stops, s + 1)
  endtask : t_write
  task automatic t_read();
    s = reqs;
    rsbr_master_i.cond(1'b0, 1'b1);
    x({ADDR ^ 7'h01, 1'b1}, 1'b1);
    `CHK(a, 1'b0)
    rsbr_master_i.cond(1'b1, 1'b0);
    rsbr_master_i.cond(1'b0, 1'b1);
    x({ADDR, 1'b1}, 1'b1);
    `CHK(a, 1'b1)
    x(8'hff, 1'b1);
    `CHK(q, 8'h96)
    rsbr_master_i.cond(1'b1, 1'b0);
    wt(10);
    `CHK(reqs, s + 1)
  endtask : t_read
  // Master lost mid-read while the slave holds SDA low
  task automatic t_recover();
    rsbr_master_i.cond(1'b0, 1'b1);
    x({ADDR, 1'b1}, 1'b1);
    for (int i = 0; i < 3; i++) rsbr_master_i.bitx(1'b1, a);
    s = stops;
    rsbr_master_i.cond(1'b1, 1'b0);
    wt(10);
    `CHK(stops, s)
    `CHK(sda_oe, 1'b1)
    wq.delete();
    rsbr_master_i.cond(1'b0, 1'b1);
    for (int i = 0; i < 63; i++) rsbr_master_i.bitx(1'b1, a);
    `CHK(sda_oe, 1'b0)
    `CHK(wq.size(), 0)
    rsbr_master_i.cond(1'b1, 1'b0);
    wt(10);
    `CHK(stops, s + 1)
  endtask : t_recover
  // Consumer stalls; ninth byte overflows the buffer
  task automatic t_fifo();
    wr_ready <= 1'b0;
    wq.delete();
    rsbr_master_i.cond(1'b0, 1'b1);
    for (int i = 0; i < 10; i++) x(i == 0 ? {ADDR, 1'b0} : 8'(8'h10 + i), 1'b1);
    rsbr_master_i.cond(1'b1, 1'b0);
    wt(10);
    wr_ready <= 1'b1;
    wt(30);
    `CHK(wq.size(), 8)
    `CHK(wq[0], 9'h111)
  endtask : t_fifo
  // One full half period of the fixed output, edge to edge
  task automatic t_wave();
    logic v;
    int n;
    v = ffo;
    while (ffo === v) wt(1);
    v = ffo;
    n = 0;
    while (ffo === v) begin
      wt(1);
      n++;
    end
    `CHK(n, rsbr_pkg::FFO_HALF_CNT + 1)
  endtask : t_wave
  initial begin
    wt(5);
    rst <= 1'b0;
    // Power-on quiet time, scaled down
    wt(2);
    t_recover();
    t_write();
    wt(1);
    rd_data <= 8'h96;
    t_read();
    wt(1);
    t_fifo();
    // Long enough for the checker to see two edges of the wave; t_wave waits for the third and fourth
    wt(3000);
    t_wave();
    wt(4);
    finish_test();
  end
endmodule : rtc_serial_bus_recovery_bench
`default_nettype wire
